// >>> crm_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// Shared reset wire with pull-up; a probe may also pull it low.
module crm_far_side
(
  input wire logic oe, od, probe,
  output logic     wire_n
);
  // Released wire floats to the pull-up level.
  assign wire_n = (oe ? od : 1'b1) & !probe;
endmodule : crm_far_side
`default_nettype wire

// >>> crm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Checks bus answers and reset paths at the controller's ports.
module crm_monitor
  import crm_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
  input wire logic [3:0]  wb_sel_i,
  // Reset pins.
  input wire logic        pushbutton_reset_in, motherboard_reset_n,
  input wire logic        board_mounted_detect_n, system_reset_od_n_i,
  input wire logic        system_reset_od_n_o, system_reset_od_n_oe,
  input wire logic        processor_por_reset_n, board_system_reset_n,
  input wire logic        bus_reset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pending request, read answer and control address hit.
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rd  = wb_ack_o && !wb_we_i;
  wire logic hit = wb_adr_i == CRM_MODULE_CONTROL_ADDR;

  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_zeros: assert property (
    rd |-> !(|(wb_dat_o & 32'h00e0_00f8))) else $error("reserved bit set");
  a_unmapped: assert property (rd && !hit |-> wb_dat_o == '0)
    else $error("unmapped data");
  a_detect_bit: assert property (rd && hit &&
    $past(board_mounted_detect_n, 8) == board_mounted_detect_n
    |-> wb_dat_o[1] == board_mounted_detect_n) else $error("detect bit");
  a_soft_pulse: assert property (req && wb_we_i && hit && wb_sel_i[0]
    && wb_dat_i[3] |-> ##3 system_reset_od_n_oe [*8]) else $error("pulse");
  a_button_pull: assert property (pushbutton_reset_in [*6]
    |-> system_reset_od_n_oe) else $error("button");
  a_drive_low: assert property (system_reset_od_n_oe |-> !system_reset_od_n_o)
    else $error("drive high");
  a_line_por: assert property (!system_reset_od_n_i [*8]
    |-> !processor_por_reset_n) else $error("line por");
  a_board_por: assert property ((!board_mounted_detect_n &&
    !motherboard_reset_n) [*8] |-> !board_system_reset_n &&
    !processor_por_reset_n) else $error("board por");
  a_bus_follow: assert property (!board_system_reset_n |=> !bus_reset_n)
    else $error("bus reset");
endmodule : crm_monitor
`default_nettype wire

// >>> crm_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module crm_pin_sync
(
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   rstn,
  // Pin levels in, filtered levels out.
  crm_sync_if.sync    pins
);
  import crm_pkg::*;

  typedef struct packed {
    logic [CRM_SYNC_WIDTH-1:0] s1;
    logic [CRM_SYNC_WIDTH-1:0] s2;
    logic [CRM_SYNC_WIDTH-1:0] s3;
    logic [CRM_SYNC_WIDTH-1:0] out;
  } crm_sync_state_t;

  crm_sync_state_t st_q;
  crm_sync_state_t st_d;

  // ------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree.
  // ------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pins.raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < CRM_SYNC_WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= {4{CRM_SYNC_RESET_VALUE}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pins.clean = st_q.out;

endmodule : crm_pin_sync
`default_nettype wire

// >>> crm_pkg.sv
package crm_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] CRM_MODULE_CONTROL_ADDR = 32'h1000_000c;
  localparam int          CRM_CTRL_LED_BIT        = 0;
  localparam int          CRM_CTRL_MOUNTED_BIT    = 1;
  localparam int          CRM_CTRL_REMAP_BIT      = 2;
  localparam int          CRM_CTRL_RESET_BIT      = 3;
  // Bits that hold what software writes; reset and detect bits excluded.
  localparam logic [31:0] CRM_CTRL_STORE_MASK     = 32'hff1f_ff05;
  localparam logic [31:0] CRM_CTRL_RESET_VALUE    = 32'h0000_0000;

  // ------------------------------------------------------------
  // Pin input positions in the synchroniser
  // ------------------------------------------------------------
  localparam int          CRM_SYNC_WIDTH          = 4;
  localparam int          CRM_IN_PUSHBUTTON       = 0;
  localparam int          CRM_IN_SYSTEM_RESET_N   = 1;
  localparam int          CRM_IN_MOUNTED_N        = 2;
  localparam int          CRM_IN_MOTHERBOARD_N    = 3;
  // Idle levels: button released, lines high, standalone, no board reset.
  localparam logic [3:0]  CRM_SYNC_RESET_VALUE    = 4'b1110;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CRM_CLK_PERIOD_NS       = 8;
  localparam int          CRM_SW_PULSE_NS         = 128;
  localparam int          CRM_SW_PULSE_CYCLES     =
    (CRM_SW_PULSE_NS + CRM_CLK_PERIOD_NS - 1) / CRM_CLK_PERIOD_NS;
  localparam logic [7:0]  CRM_SW_PULSE_LOAD       =
    8'(CRM_SW_PULSE_CYCLES);

endpackage : crm_pkg

// >>> crm_reset_ctrl.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Resets come from button, motherboard, other modules, probe, software.
// - Processor reset follows line when standalone, board reset when mounted.
// - Drive open-collector reset line low on button or software pulse.
// - Standalone, the reset line is synchronised before feeding processor.
// - System controller makes board reset; it also drives bus reset.
// - Software reset bit write makes pulse that pulls the line low.
// - Writing 1 to reset bit triggers; the bit always reads 0.
// - Read-only detect bit reads 0 when mounted; selects reset path.
module crm_reset_ctrl
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Classic Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Reset sources.
  input  wire logic        pushbutton_reset_in,
  input  wire logic        motherboard_reset_n,
  input  wire logic        board_mounted_detect_n,
  // Open-collector system reset line.
  input  wire logic        system_reset_od_n_i,
  output logic             system_reset_od_n_o,
  output logic             system_reset_od_n_oe,
  // Generated resets.
  output logic             processor_por_reset_n,
  output logic             board_system_reset_n,
  output logic             bus_reset_n,
  // Stored control bits for the rest of the module.
  output logic      [31:0] module_control_out
);
  import crm_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [7:0]  sw_cnt;
    logic        line_drive;
    logic        board_rst_n;
    logic        bus_rst_n;
    logic        por_n;
  } crm_state_t;

  crm_state_t   st_q;
  crm_state_t   st_d;
  crm_sync_if   pins ();

  logic         req;
  logic         hit;
  logic         sw_trigger;
  logic         button_s;
  logic         line_low_s;
  logic         mounted_n_s;
  logic         board_low_s;
  logic [31:0]  wmask;
  logic [31:0]  read_word;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------

  // Every external reset source is filtered before use.
  assign pins.raw[CRM_IN_PUSHBUTTON]     = pushbutton_reset_in;
  assign pins.raw[CRM_IN_SYSTEM_RESET_N] = system_reset_od_n_i;
  assign pins.raw[CRM_IN_MOUNTED_N]      = board_mounted_detect_n;
  assign pins.raw[CRM_IN_MOTHERBOARD_N]  = motherboard_reset_n;

  crm_pin_sync u_sync
  (
    .clk  (clk),
    .rstn (rstn),
    .pins (pins.sync)
  );

  // Filtered levels, with lows turned into active-high requests.
  assign button_s    = pins.clean[CRM_IN_PUSHBUTTON];
  assign line_low_s  = !pins.clean[CRM_IN_SYSTEM_RESET_N];
  assign mounted_n_s = pins.clean[CRM_IN_MOUNTED_N];
  assign board_low_s = !pins.clean[CRM_IN_MOTHERBOARD_N];

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------

  // A request is served once; ack falls in the cycle after it rose.
  assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign hit = (wb_adr_i == CRM_MODULE_CONTROL_ADDR);

  // Byte enables widened to a bit mask.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  // Software reset fires on a write of 1 to the reset bit.
  assign sw_trigger = req && hit && wb_we_i
                      && wb_sel_i[0] && wb_dat_i[CRM_CTRL_RESET_BIT];

  // Read view: reset bit reads 0, detect bit shows the pin.
  always_comb
  begin
    read_word                       = st_q.ctrl & CRM_CTRL_STORE_MASK;
    read_word[CRM_CTRL_RESET_BIT]   = 1'b0;
    read_word[CRM_CTRL_MOUNTED_BIT] = mounted_n_s;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    st_d.ack = req;

    // Register access; unmapped addresses ack and read zero.
    if (req)
    begin
      st_d.rdata = 32'h0000_0000;
      if (hit && wb_we_i)
      begin
        st_d.ctrl = (st_q.ctrl & ~(wmask & CRM_CTRL_STORE_MASK))
                    | (wb_dat_i & wmask & CRM_CTRL_STORE_MASK);
      end
      else if (hit)
      begin
        st_d.rdata = read_word;
      end
    end

    // Software pulse: loads a counter, held for a fixed time.
    if (sw_trigger)
    begin
      st_d.sw_cnt = CRM_SW_PULSE_LOAD;
    end
    else if (st_q.sw_cnt != 8'h00)
    begin
      st_d.sw_cnt = st_q.sw_cnt - 8'h01;
    end

    // Pull the shared line low for button or software pulse.
    st_d.line_drive = button_s || (st_q.sw_cnt != 8'h00);

    // System controller: any reset origin resets the board.
    st_d.board_rst_n = !(line_low_s || board_low_s);
    st_d.bus_rst_n   = st_q.board_rst_n;

    // Path choice by mount detect; release on a clock edge.
    if (!mounted_n_s)
    begin
      st_d.por_n = st_q.board_rst_n;
    end
    else
    begin
      st_d.por_n = !line_low_s;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q.ack         <= 1'b0;
      st_q.rdata       <= 32'h0000_0000;
      st_q.ctrl        <= CRM_CTRL_RESET_VALUE;
      st_q.sw_cnt      <= 8'h00;
      st_q.line_drive  <= 1'b0;
      st_q.board_rst_n <= 1'b0;
      st_q.bus_rst_n   <= 1'b0;
      st_q.por_n       <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Open collector: only ever drives low.
  assign system_reset_od_n_o   = 1'b0;
  assign system_reset_od_n_oe  = st_q.line_drive;
  assign processor_por_reset_n = st_q.por_n;
  assign board_system_reset_n  = st_q.board_rst_n;
  assign bus_reset_n           = st_q.bus_rst_n;
  assign wb_ack_o              = st_q.ack;
  assign wb_dat_o              = st_q.rdata;
  assign module_control_out    = st_q.ctrl & CRM_CTRL_STORE_MASK;

endmodule : crm_reset_ctrl
`default_nettype wire

// >>> crm_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries raw pin levels into the synchroniser and filtered levels back.
interface crm_sync_if;
  import crm_pkg::*;
  logic [CRM_SYNC_WIDTH-1:0] raw;
  logic [CRM_SYNC_WIDTH-1:0] clean;
  modport owner (output raw, input clean);
  modport sync  (input raw, output clean);
endinterface : crm_sync_if
`default_nettype wire

// >>> tb_crm_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Drives the controller over its bus and reset pins.
module tb_crm_reset_ctrl;
  import crm_pkg::*;
  logic        clk, rstn, cyc, stb, we, pb, mb_n, det_n, probe, ack;
  logic        wire_n, od, oe, por, bsr, bus;
  logic [3:0]  sel;
  logic [31:0] adr, wd, rd, dat, mco;
  int          n_errors, check_count, cycles;
  localparam logic [31:0] A = CRM_MODULE_CONTROL_ADDR;

  crm_reset_ctrl crm_reset_ctrl_inst (.clk, .rstn, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
    .pushbutton_reset_in(pb), .motherboard_reset_n(mb_n),
    .board_mounted_detect_n(det_n), .system_reset_od_n_i(wire_n),
    .system_reset_od_n_o(od), .system_reset_od_n_oe(oe),
    .processor_por_reset_n(por), .board_system_reset_n(bsr),
    .bus_reset_n(bus), .module_control_out(mco));
  crm_far_side crm_far_side_inst (.oe, .od, .probe, .wire_n);

  // Clock and a ceiling on run length.
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // One classic cycle; held until ack is seen.
  task automatic wb(logic w, logic [31:0] a, d, logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat;
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic await(ref logic s, input logic v);
    for (int k = 0; k < 40 && s !== v; k++) @(posedge clk);
  endtask : await

  task automatic t_regs();
    wb(1, A, 32'hffff_fff7, 4'hf);
    wb(0, A, 0, 0);
    check(rd, 32'hff1f_ff07);
    wb(1, A + 4, 0, 4'hf);
    wb(0, A + 4, 0, 0);
    check(rd, 0);
    check(mco, 32'hff1f_ff05);
  endtask : t_regs

  task automatic t_soft();
    wb(1, A, 32'h0000_0008, 4'h1);
    await(oe, 1);
    check(oe, 1);
    await(por, 0);
    check(por, 0);
    check(bsr, 0);
    wb(0, A, 0, 0);
    check(rd, 32'hff1f_ff02);
    check(bus, 0);
    await(por, 1);
    check(por, 1);
  endtask : t_soft

  task automatic t_pins();
    pb <= 1;
    await(por, 0);
    check(oe, 1);
    pb <= 0;
    await(por, 1);
    probe <= 1;
    await(por, 0);
    check(oe, 0);
    probe <= 0;
    await(por, 1);
    check(por, 1);
  endtask : t_pins

  task automatic t_mount();
    mb_n <= 0;
    repeat (12) @(posedge clk);
    check({bsr, por}, 2'b01);
    det_n <= 0;
    await(por, 0);
    check(por, 0);
    wb(0, A, 0, 0);
    check(rd, 32'hff1f_ff00);
    mb_n <= 1;
    await(por, 1);
    check(por, 1);
  endtask : t_mount

  // Reset, then each scenario in turn.
  initial
  begin
    {rstn, cyc, stb, we, pb, probe, adr, wd, sel} = '0;
    {mb_n, det_n} = 2'b11;
    repeat (3) @(posedge clk);
    rstn <= 1;
    t_regs();
    t_soft();
    t_pins();
    t_mount();
    stop_test();
  end
endmodule : tb_crm_reset_ctrl
bind crm_reset_ctrl crm_monitor crm_monitor_inst (.*);
`default_nettype wire
